//--- usb_port_device_model.sv
/* portable devices on the two ports
   assumes the bench sets which ports hold a device */
`default_nettype none
module usb_port_device_model (
    input wire logic clk,
    input wire logic [1:0] plugged,
    input wire logic [1:0] powered,
    output logic [1:0] currentHigh
);
    timeunit 1ns;
    timeprecision 1ps;
    // load current only while plugged in and fed
    always_ff @(posedge clk) currentHigh <= plugged & powered;
endmodule // usb_port_device_model
`default_nettype wire

//--- usb_port_power_map.vh
/*
 * register offsets, field positions, reset values and timing counts
 * for the two-port power state controller.
 * assumes a 50 MHz clock and word-aligned avalon-mm byte addresses.
 */
`ifndef USB_PORT_POWER_MAP_VH
`define USB_PORT_POWER_MAP_VH

`define CTRL_OFFSET 4'h0
`define STATE_OFFSET 4'h4
`define FAULT_OFFSET 4'h8
`define CHARGE1_OFFSET 4'hc

`define CTRL_ATTACH_QUALIFY_BIT 0
`define CTRL_RESET 32'h00000001

`define ST_OFF 3'h0
`define ST_SLEEP 3'h1
`define ST_DETECT 3'h2
`define ST_ACTIVE 3'h3
`define ST_ERROR 3'h4

`define CLK_MHZ 50
`define ATTACH_QUALIFY_TIME_US 100
`define ATTACH_QUALIFY_CYCLES (`ATTACH_QUALIFY_TIME_US * `CLK_MHZ)
`define IDLE_SLEEP_TIME_MS 5
`define IDLE_SLEEP_CYCLES (`IDLE_SLEEP_TIME_MS * 1000 * `CLK_MHZ)

`endif

//--- usb_port_power_state_control.v
/*
 * power state controller for a two-port usb power switch: chooses
 * off, sleep, detect, active or error and drives the port and bypass
 * switches; registers over avalon-mm with waitrequest.
 * assumes supply, enables, attach currents and faults arrive
 * asynchronously from analog comparators and are synchronised here.
 * assumes the bus master holds a request until it sees waitrequest low,
 * and that a low supply level is the only power-on reset there is.
 * every supply, enable, attach and fault level takes two clock edges of synchronising before
 * the state choice or the switches react to it.
 */
// The address map and the Avalon-MM slave port are this design's own decisions.
// Notes on behaviour
// - supply below threshold: off, state lost, bus ignored, all switches open.
// - sleep is lowest power but keeps logic and answers bus traffic.
// - both enables low gives sleep and opens every switch.
// - detect waits for attach on enabled ports and keeps configuration.
// - detect does no charge accounting; bus stays fully usable.
// - qualify on, port enabled, nothing attached: detect, then active on attach.
// - each enabled port goes active under its own attach conditions.
// - a disabled port beside an enabled one only gets bypass current.
// - active with qualify on: port one switch closed only while attached.
// - active with qualify on: port two switch closed only while attached.
// - qualify off and port enabled: forced active, switch always closed.
// - any channel fault gives error, first priority.
// - a fault is recorded in that channel's status bit.
// - fault handling touches only the faulted channel.
// - active is second priority: no fault and a port sourcing.
// - active drives the switch and does charge accounting for port one only.
// - attach when current stays above qualify level past qualify time.
// - first read in sleep wakes the device and returns zero.
// - after a wake by read, return to sleep after idle interval.
`include "usb_port_power_map.vh"
`default_nettype none

module usb_port_power_state_control #(
    parameter integer QUALIFY_CYCLES = `ATTACH_QUALIFY_CYCLES,
    parameter integer IDLE_CYCLES = `IDLE_SLEEP_CYCLES
) (
    input wire clk,
    input wire srst,
    input wire supplyOk,
    input wire port1PowerEnable,
    input wire port2PowerEnable,
    input wire [1:0] attachCurrentHigh,
    input wire [1:0] faultSense,
    input wire [3:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    output reg [31:0] readdata,
    output reg waitrequest,
    output reg [1:0] portSwitchOn,
    output reg [1:0] bypassOn,
    output reg [1:0] attachedFlag,
    output reg [2:0] powerState
);

    localparam integer QW = 24;
    localparam integer IW = 28;
    localparam [31:0] CTRL_INIT = `CTRL_RESET;

    reg [6:0] sync1_r;
    reg [6:0] sync2_r;
    wire [1:0] portEnable;
    wire supplyUp;
    wire [1:0] curHigh;
    wire [1:0] fault;

    reg ctrl_r;
    reg [1:0] faultSticky_r;
    reg awake_r;
    reg [IW-1:0] idleCnt_r;
    reg [31:0] charge1_r;
    reg [2:0] state_nxt;
    reg [2:0] chanState [0:1];
    reg [QW-1:0] qualCnt_r [0:1];
    reg [1:0] attached_r;
    reg [1:0] portSwitch_nxt;
    reg [1:0] bypass_nxt;

    always @(posedge clk) begin
        sync1_r <= {supplyOk, port2PowerEnable, port1PowerEnable, attachCurrentHigh, faultSense};
        sync2_r <= sync1_r;
    end

    assign supplyUp = sync2_r[6];
    assign portEnable = sync2_r[5:4];
    assign curHigh = sync2_r[3:2];
    assign fault = sync2_r[1:0];

    wire sleepReq = ~portEnable[0] & ~portEnable[1];
    wire bus = (read | write) & waitrequest & supplyUp;

    // the first read in sleep is a dummy that only wakes the logic
    wire dummyRead = (powerState == `ST_SLEEP) && !awake_r;
    wire idleDone = (idleCnt_r >= IDLE_CYCLES[IW-1:0]);

    // per-channel evaluation, fault first then enable then attach
    function [2:0] chanNext;
        input en;
        input flt;
        input att;
        input qual;
        begin
            if (flt)
                chanNext = `ST_ERROR;
            else if (!en)
                chanNext = `ST_SLEEP;
            else if (!qual)
                chanNext = `ST_ACTIVE;
            else if (att)
                chanNext = `ST_ACTIVE;
            else
                chanNext = `ST_DETECT;
        end
    endfunction

    // register address match, word aligned
    function regHit;
        input [3:0] addr;
        input [3:0] offset;
        begin
            regHit = (addr == offset);
        end
    endfunction

    // read mux for the four mapped registers
    function [31:0] regWord;
        input [3:0] addr;
        input ctrlBit;
        input [1:0] att;
        input [2:0] st;
        input [1:0] flt;
        input [31:0] chg;
        begin
            if (regHit(addr, `CTRL_OFFSET))
                regWord = {31'h0, ctrlBit};
            else if (regHit(addr, `STATE_OFFSET))
                regWord = {27'h0, att, st};
            else if (regHit(addr, `FAULT_OFFSET))
                regWord = {30'h0, flt};
            else if (regHit(addr, `CHARGE1_OFFSET))
                regWord = chg;
            else
                regWord = 32'h0;
        end
    endfunction

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : chan
            always @(posedge clk) begin
                if (srst || !supplyUp) begin
                    qualCnt_r[g] <= {QW{1'b0}};
                    attached_r[g] <= 1'b0;
                end else if (!portEnable[g] || fault[g] || !ctrl_r) begin
                    qualCnt_r[g] <= {QW{1'b0}};
                    attached_r[g] <= 1'b0;
                end else if (!attached_r[g]) begin
                    if (!curHigh[g])
                        qualCnt_r[g] <= {QW{1'b0}};
                    else if (qualCnt_r[g] >= QUALIFY_CYCLES[QW-1:0])
                        attached_r[g] <= 1'b1;
                    else
                        qualCnt_r[g] <= qualCnt_r[g] + 1'b1;
                end
            end
            always @* begin
                chanState[g] = chanNext(portEnable[g], fault[g], attached_r[g],
                    ctrl_r);
            end
        end
    endgenerate

    // per-port switch and bypass choice
    generate
        for (g = 0; g < 2; g = g + 1) begin : sw
            always @* begin
                portSwitch_nxt[g] = 1'b0;
                bypass_nxt[g] = 1'b0;
                case (chanState[g])
                    `ST_ACTIVE: begin
                        portSwitch_nxt[g] = 1'b1;
                    end
                    `ST_DETECT: begin
                        bypass_nxt[g] = 1'b1;
                    end
                    `ST_SLEEP: begin
                        bypass_nxt[g] = ~sleepReq;
                    end
                    default: begin
                        portSwitch_nxt[g] = 1'b0;
                    end
                endcase
            end
        end
    endgenerate

    // device state: error over active over sleep over detect
    always @* begin
        if (!supplyUp)
            state_nxt = `ST_OFF;
        else if (fault != 2'b00)
            state_nxt = `ST_ERROR;
        else if (chanState[0] == `ST_ACTIVE || chanState[1] == `ST_ACTIVE)
            state_nxt = `ST_ACTIVE;
        else if (sleepReq)
            state_nxt = `ST_SLEEP;
        else
            state_nxt = `ST_DETECT;
    end

    always @(posedge clk) begin
        if (srst || !supplyUp) begin
            powerState <= `ST_OFF;
            portSwitchOn <= 2'b00;
            bypassOn <= 2'b00;
            attachedFlag <= 2'b00;
        end else begin
            powerState <= state_nxt;
            portSwitchOn <= portSwitch_nxt;
            bypassOn <= bypass_nxt;
            attachedFlag <= attached_r;
        end
    end

    // charge accounting only while port one sources, in active or with port two faulted
    always @(posedge clk) begin
        if (srst || !supplyUp)
            charge1_r <= 32'h0;
        else if (portSwitchOn[0] && curHigh[0])
            charge1_r <= charge1_r + 32'h1;
    end

    // faults are sticky per channel; a new fault wins over a clear
    always @(posedge clk) begin
        if (srst || !supplyUp)
            faultSticky_r <= 2'b00;
        else if (bus && write && regHit(address, `FAULT_OFFSET))
            faultSticky_r <= (faultSticky_r & ~writedata[1:0]) | fault;
        else
            faultSticky_r <= faultSticky_r | fault;
    end

    // wake on the first read in sleep, fall back after idle
    always @(posedge clk) begin
        if (srst || !supplyUp) begin
            awake_r <= 1'b0;
            idleCnt_r <= {IW{1'b0}};
        end else if (powerState != `ST_SLEEP) begin
            awake_r <= 1'b0;
            idleCnt_r <= {IW{1'b0}};
        end else if (bus) begin
            idleCnt_r <= {IW{1'b0}};
            if (read)
                awake_r <= 1'b1;
        end else if (awake_r) begin
            if (idleDone)
                awake_r <= 1'b0;
            else
                idleCnt_r <= idleCnt_r + 1'b1;
        end
    end

    // avalon-mm slave: one wait cycle, answer on the second edge
    always @(posedge clk) begin
        if (srst || !supplyUp) begin
            waitrequest <= 1'b1;
            readdata <= 32'h0;
            ctrl_r <= CTRL_INIT[0];
        end else if (bus) begin
            waitrequest <= 1'b0;
            readdata <= 32'h0;
            if (read && !dummyRead) begin
                readdata <= regWord(address, ctrl_r, attached_r, powerState,
                    faultSticky_r, charge1_r);
            end
            if (write && regHit(address, `CTRL_OFFSET))
                ctrl_r <= writedata[`CTRL_ATTACH_QUALIFY_BIT];
        end else begin
            waitrequest <= 1'b1;
        end
    end

endmodule // usb_port_power_state_control

`default_nettype wire

//--- usb_port_power_state_control_asserts.sv
/* port assertions for the power state controller
   assumes the design's clk and srst, bound by name */
`include "usb_port_power_map.vh"
`default_nettype none
module usb_port_power_state_control_asserts (
    input wire logic clk,
    input wire logic srst,
    input wire logic supplyOk,
    input wire logic port1PowerEnable,
    input wire logic port2PowerEnable,
    input wire logic [1:0] faultSense,
    input wire logic waitrequest,
    input wire logic [1:0] portSwitchOn,
    input wire logic [1:0] bypassOn,
    input wire logic [2:0] powerState
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    off_switches_a: assert property (powerState == `ST_OFF |-> (portSwitchOn | bypassOn) == 2'h0)
        else $error("switch closed in off");
    sleep_entry_a: assert property ((!port1PowerEnable && !port2PowerEnable && supplyOk
        && faultSense == 2'h0)[*5] |-> powerState == `ST_SLEEP)
        else $error("no sleep with both enables low");
    error_first_a: assert property ((faultSense != 2'h0 && supplyOk)[*5] |-> powerState == `ST_ERROR)
        else $error("fault without error state");
    fault_port_a: assert property ((faultSense[1] && supplyOk)[*5] |-> !portSwitchOn[1] && !bypassOn[1])
        else $error("faulted port still fed");
    active_source_a: assert property (powerState == `ST_ACTIVE |-> portSwitchOn != 2'h0)
        else $error("active with no port sourcing");
    detect_open_a: assert property (powerState == `ST_DETECT |-> portSwitchOn == 2'h0)
        else $error("switch closed in detect");
    switch_bypass_a: assert property ((portSwitchOn & bypassOn) == 2'h0)
        else $error("switch and bypass both on");
    wait_pulse_a: assert property ($fell(waitrequest) |=> waitrequest)
        else $error("answer longer than one cycle");
endmodule // usb_port_power_state_control_asserts
bind usb_port_power_state_control usb_port_power_state_control_asserts u_chk (.clk(clk),
    .srst(srst), .supplyOk(supplyOk), .port1PowerEnable(port1PowerEnable),
    .port2PowerEnable(port2PowerEnable), .faultSense(faultSense), .waitrequest(waitrequest),
    .portSwitchOn(portSwitchOn), .bypassOn(bypassOn), .powerState(powerState));
`default_nettype wire

//--- usb_port_power_state_control_tb_top.sv
/* self-checking bench for the power state controller
   assumes the map header and the device model */
`include "usb_port_power_map.vh"
`default_nettype none
module usb_port_power_state_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, srst, supplyOk, port1PowerEnable, port2PowerEnable, read, write, waitrequest;
    logic [1:0] attachCurrentHigh, faultSense, portSwitchOn, bypassOn, attachedFlag, plugged;
    logic [3:0] address;
    logic [31:0] writedata, readdata, q;
    logic [2:0] powerState;
    int fails, num_checks;
    usb_port_power_state_control #(.QUALIFY_CYCLES(8), .IDLE_CYCLES(20))
        u_usb_port_power_state_control (.clk, .srst, .supplyOk, .port1PowerEnable,
        .port2PowerEnable, .attachCurrentHigh, .faultSense, .address, .read, .write,
        .writedata, .readdata, .waitrequest, .portSwitchOn, .bypassOn, .attachedFlag, .powerState);
    usb_port_device_model u_usb_port_device_model (.clk, .plugged,
        .powered(portSwitchOn | bypassOn), .currentHigh(attachCurrentHigh));
    task summarize;
        $display("checks=%0d fails=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        read <= !w;
        write <= w;
        address <= a;
        writedata <= d;
        @(posedge clk);
        while (waitrequest !== 1'h0 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n == 50) fails++;
        q = readdata;
        read <= 1'h0;
        write <= 1'h0;
        @(posedge clk);
    endtask
    task waitSt(input logic [2:0] s);
        int n;
        n = 0;
        while (powerState !== s && n < 100) begin
            @(posedge clk);
            n++;
        end
        if (n == 100) fails++;
        repeat (2) @(posedge clk);
    endtask
    task tSleep;
        waitSt(`ST_SLEEP);
        chk(portSwitchOn | bypassOn, 32'h0);
        bus(1'h0, `STATE_OFFSET, 32'h0);
        chk(q, 32'h0);
        bus(1'h0, `STATE_OFFSET, 32'h0);
        chk(q[2:0], `ST_SLEEP);
        bus(1'h0, `CTRL_OFFSET, 32'h0);
        chk(q, `CTRL_RESET);
        $display("sleep test done");
    endtask
    task tAttach;
        plugged <= 2'h1;
        port1PowerEnable <= 1'h1;
        waitSt(`ST_DETECT);
        chk(portSwitchOn, 32'h0);
        waitSt(`ST_ACTIVE);
        chk({attachedFlag, portSwitchOn, bypassOn}, 32'h16);
        $display("attach test done");
    endtask
    task tForced;
        plugged <= 2'h0;
        port2PowerEnable <= 1'h1;
        bus(1'h0, 4'h2, 32'h0);
        chk(q, 32'h0);
        bus(1'h1, `CTRL_OFFSET, 32'h0);
        repeat (6) @(posedge clk);
        chk(portSwitchOn, 32'h3);
        port1PowerEnable <= 1'h0;
        repeat (6) @(posedge clk);
        chk({portSwitchOn, bypassOn}, 32'h9);
        $display("forced test done");
    endtask
    task tFault;
        port1PowerEnable <= 1'h1;
        faultSense <= 2'h2;
        waitSt(`ST_ERROR);
        chk(portSwitchOn, 32'h1);
        bus(1'h0, `FAULT_OFFSET, 32'h0);
        chk(q[1:0], 32'h2);
        faultSense <= 2'h0;
        repeat (4) @(posedge clk);
        bus(1'h1, `FAULT_OFFSET, 32'h2);
        bus(1'h0, `FAULT_OFFSET, 32'h0);
        chk(q[1:0], 32'h0);
        waitSt(`ST_ACTIVE);
        chk(portSwitchOn, 32'h3);
        $display("fault test done");
    endtask
    task tOff;
        supplyOk <= 1'h0;
        waitSt(`ST_OFF);
        chk(portSwitchOn | bypassOn, 32'h0);
        supplyOk <= 1'h1;
        waitSt(`ST_DETECT);
        bus(1'h0, `CTRL_OFFSET, 32'h0);
        chk(q, `CTRL_RESET);
        $display("off test done");
    endtask
    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end
    initial begin
        #100us;
        fails++;
        summarize;
    end
    initial begin
        {srst, supplyOk, port1PowerEnable, port2PowerEnable, read, write} = 6'h30;
        {faultSense, plugged, address, writedata} = 40'h0;
        repeat (16) @(posedge clk);
        srst <= 1'h0;
        tSleep;
        tAttach;
        tForced;
        tFault;
        tOff;
        summarize;
    end
endmodule // usb_port_power_state_control_tb_top
`default_nettype wire
